// ===== bench/midi_instrument.sv
`timescale 1ns/10ps
`default_nettype none
module midi_instrument #(
    parameter int BIT_CYC = 1280
) (
    // Clock.
    input  wire logic        clk,
    // Serial link.
    input  wire logic        serial_midi_out,
    output logic             serial_midi_in,
    // Capture results.
    output logic      [7:0]  got_byte,
    output logic      [15:0] got_count,
    output logic      [15:0] low_len
);
    logic [15:0] run;
    logic [7:0]  sh;

    initial begin
        serial_midi_in = 1'b1;
        got_count = 16'h0000;
        got_byte = 8'h00;
        low_len = 16'h0000;
        run = 16'h0000;
    end

    // Length of the latest low run, so the bench can judge the bit period.
    always @(posedge clk) begin
        if (serial_midi_out === 1'b0) begin
            run <= run + 16'h0001;
        end else if (run != 16'h0000) begin
            low_len <= run;
            run <= 16'h0000;
        end
    end

    // Samples each bit at its centre; a frame without a high stop bit is not counted.
    always begin
        @(negedge serial_midi_out);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            sh[i] = serial_midi_out;
        end
        repeat (BIT_CYC) @(posedge clk);
        if (serial_midi_out === 1'b1) begin
            got_byte <= sh;
            got_count <= got_count + 16'h0001;
        end
    end

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_midi_in <= f[i];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask : send_byte
endmodule : midi_instrument
`default_nettype wire

// ===== bench/test_midi_uart_host_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_midi_uart_host_port;
    import midi_uart_pkg::*;
    typedef struct packed {
        byte_t cmd;
        logic  two;
        byte_t reply;
    } row_t;
    // Base sits on an eight-location boundary.
    localparam logic [9:0]  BASE  = 10'h330;
    localparam logic [15:0] PORT0 = 16'h0330;
    localparam logic [15:0] PORT1 = 16'h0331;
    localparam row_t ROWS[7] = '{'{8'ha0, 1'b1, 8'h00}, '{8'ha7, 1'b1, 8'h00},
        '{8'hab, 1'b1, 8'h00}, '{8'hac, 1'b1, 8'h15}, '{8'had, 1'b1, 8'h01},
        '{8'haf, 1'b1, 8'h64}, '{8'h12, 1'b0, 8'hfe}};
    logic        clk;
    logic        sys_rst;
    logic        io_rd;
    logic        io_wr;
    logic        io_sel;
    logic        host_irq;
    logic        serial_midi_in;
    logic        serial_midi_out;
    logic [15:0] io_addr;
    logic [15:0] got_count;
    logic [15:0] low_len;
    byte_t       io_wdata;
    byte_t       io_rdata;
    byte_t       got_byte;
    byte_t       d;
    byte_t       q[$];
    int          fails;
    int          checks;

    midi_uart_host_port dut (
        .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .midi_port_base(BASE),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_sel(io_sel), .host_irq(host_irq), .serial_midi_in(serial_midi_in),
        .serial_midi_out(serial_midi_out));
    midi_instrument u_inst (
        .clk(clk), .serial_midi_out(serial_midi_out), .serial_midi_in(serial_midi_in),
        .got_byte(got_byte), .got_count(got_count), .low_len(low_len));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string n, input byte_t seen, input byte_t exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // One strobe cycle, then one low cycle before the next access.
    task automatic acc(input logic wr, input logic [15:0] a, input byte_t w);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= w;
        io_wr <= wr;
        io_rd <= !wr;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1 d = io_rdata;
    endtask : acc

    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        sys_rst = 1'b1;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
        fails = 0;
        checks = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        check("irq at reset", {7'h0, host_irq}, 8'h00);
        check("line idle", {7'h0, serial_midi_out}, 8'h01);
        acc(1'b0, PORT1, 8'h00);
        check("status after reset", d, 8'h80);
        acc(1'b1, PORT0, 8'h77);
        @(posedge clk);
        io_addr <= PORT1;
        #1 check("own select", {7'h0, io_sel}, 8'h01);
        @(posedge clk);
        io_addr <= PORT1 | 16'h0400;
        #1 check("alias select", {7'h0, io_sel}, 8'h00);
        @(posedge clk);
        io_addr <= PORT0 + 16'h0002;
        #1 check("third place select", {7'h0, io_sel}, 8'h00);
        foreach (ROWS[i]) begin
            acc(1'b1, PORT1, ROWS[i].cmd);
            q.push_back(8'hfe);
            if (ROWS[i].two) begin
                q.push_back(ROWS[i].reply);
            end
            acc(1'b0, PORT0, 8'h00);
            check("peek byte", d, ROWS[i].reply);
            acc(1'b0, PORT1, 8'h00);
            check("status echo", d, {2'b00, ROWS[i].cmd[5:0]});
            check("irq raised", {7'h0, host_irq}, 8'h01);
        end
        acc(1'b1, PORT1, 8'h3f);
        q.push_back(8'hfe);
        while (q.size() > 0) begin
            acc(1'b0, PORT0, 8'h00);
            check("popped byte", d, q.pop_front());
            check("irq level", {7'h0, host_irq}, {7'h0, q.size() > 0});
        end
        acc(1'b1, PORT1, 8'h55);
        acc(1'b0, PORT1, 8'h00);
        check("silent command", d, 8'h95);
        acc(1'b1, PORT0, 8'h5b);
        for (int k = 0; k < 15000 && got_count == 16'h0000; k++) @(posedge clk);
        check("sent count", got_count[7:0], 8'h01);
        check("sent byte", got_byte, 8'h5b);
        check("bit period ok", {7'h0, low_len >= 16'd1268 && low_len <= 16'd1292}, 8'h01);
        u_inst.send_byte(8'hc3);
        for (int k = 0; k < 2000 && host_irq !== 1'b1; k++) @(posedge clk);
        acc(1'b0, PORT0, 8'h00);
        check("received byte", d, 8'hc3);
        acc(1'b1, PORT1, 8'hff);
        acc(1'b1, PORT1, 8'h12);
        acc(1'b0, PORT1, 8'h00);
        check("back to command mode", d, 8'h12);
        for (int i = 0; i < 14; i++) acc(1'b1, PORT1, 8'h12);
        acc(1'b1, PORT1, 8'hac);
        acc(1'b0, PORT1, 8'h00);
        check("rx full status", d, 8'h2c);
        check("newest overwritten", dut.u_rx_fifo.mem[dut.u_rx_fifo.wr_ff - 4'h1], 8'h15);
        acc(1'b1, PORT1, 8'h3f);
        for (int i = 1; i <= 17; i++) begin
            acc(1'b1, PORT0, i[7:0]);
            if (i >= 16) begin
                acc(1'b0, PORT1, 8'h00);
                check("tx full flag", d & 8'h40, (i == 17) ? 8'h40 : 8'h00);
            end
        end
        acc(1'b1, PORT0, 8'h99);
        acc(1'b0, PORT1, 8'h00);
        check("full after drop", d, 8'h7f);
        check("queue kept", dut.u_tx_fifo.mem[dut.u_tx_fifo.wr_ff - 4'h1], 8'h11);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        check("rdata after reset", io_rdata, 8'h00);
        check("line idle after reset", {7'h0, serial_midi_out}, 8'h01);
        acc(1'b0, PORT1, 8'h00);
        check("status after second reset", d, 8'h80);
        check("irq after second reset", {7'h0, host_irq}, 8'h00);
        acc(1'b1, PORT1, 8'h12);
        acc(1'b0, PORT1, 8'h00);
        check("command-only after reset", d, 8'h12);
        tally_and_finish();
    end
endmodule : test_midi_uart_host_port
`default_nettype wire

// ===== src/byte_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Overwrite the newest entry when full and not popped in the same cycle.
    input  wire logic             in_ovr,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;
    logic             ovr;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign ovr       = in_valid && !in_ready && in_ovr && !pop;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end else if (ovr) begin
            mem[wr_ff - AW'(1)] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + AW'(1);
            end
            if (pop) begin
                rd_ff <= rd_ff + AW'(1);
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : byte_fifo
`default_nettype wire

// ===== src/midi_uart_defs.svh
`ifndef MIDI_UART_DEFS_SVH
`define MIDI_UART_DEFS_SVH

`define ADDR_W          16
`define DEC_W           10
`define DATA_OFS        1'b0
`define CMD_OFS         1'b1
`define ECHO_W          6
`define TXF_BIT         6
`define RXE_BIT         7
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define CLK_HZ          40000000
`define BAUD_HZ         31250
`define BIT_CYC         (`CLK_HZ / `BAUD_HZ)
`define BIT_CNT_W       11
`define HALF_CYC        (`BIT_CYC / 2)
`define CMD_ENTER       8'h3f
`define CMD_EXIT        8'hff
`define ACK_BYTE        8'hfe
`define REPLY_ZERO      8'h00
`define CMD_AC          8'hac
`define REPLY_AC        8'h15
`define CMD_AD          8'had
`define REPLY_AD        8'h01
`define CMD_AF          8'haf
`define REPLY_AF        8'h64
`define CMD_AB          8'hab
`define CMD_A0_HI       5'h14
`define LAST_BIT        4'h9
`define STOP_BIT        4'h8

`endif

// ===== src/midi_uart_host_port.sv
// Functional notes
// RULE1 - Ten-bit decode, upper address bits zero
// RULE2 - Offset zero data, offset one command/status
// RULE3 - Host places base on eight-location boundary
// RULE4 - Sixteen-entry transmit and receive FIFOs
// RULE5 - Status bits 5:0 echo last command
// RULE6 - Status bit six: transmit FIFO full
// RULE7 - Status bit seven: receive FIFO empty
// RULE8 - Receive push raises interrupt; data read clears
// RULE9 - Receive FIFO fed by serial and replies
// RULE10 - Serial rate 31.25 kbaud from clock
// RULE11 - One start, eight data, one stop
// RULE12 - Reset enters command-only mode
// RULE13 - Command-only: data writes dropped, reads peek
// RULE14 - 3Fh enters pass-through, acknowledges FEh
// RULE15 - Ax commands push FEh then reply; A8h-AAh and AEh push FEh only
// RULE16 - Other commands still acknowledged FEh
// RULE17 - Pass-through writes queue, transmitter drains
// RULE18 - Pass-through reads pop receive FIFO
// RULE19 - Full receive FIFO overwrites newest entry; the code drops a byte that arrives in the same cycle as a pop
// RULE20 - FFh returns to command-only mode
// RULE21 - Other pass-through commands ignored silently
// RULE22 - Write to full transmit FIFO dropped
// RULE23 - Interrupt held while receive data remains
`timescale 1ns/10ps
`default_nettype none
`include "midi_uart_defs.svh"
module midi_uart_host_port
    import midi_uart_pkg::*;
(
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Host I/O bus.
    input  wire logic [`ADDR_W-1:0]    io_addr,
    input  wire logic [`DEC_W-1:0]     midi_port_base,
    input  wire logic                  io_rd,
    input  wire logic                  io_wr,
    input  wire midi_uart_pkg::byte_t  io_wdata,
    output midi_uart_pkg::byte_t       io_rdata,
    output logic                       io_sel,
    output logic                       host_irq,
    // Serial link.
    input  wire logic                  serial_midi_in,
    output logic                       serial_midi_out
);
    byte_t           rdata_ff;
    logic            pass_ff;
    logic [5:0]      command_echo_bits_ff;
    byte_t           reply_ff;
    logic            reply_pend_ff;
    byte_t           last_rx_ff;
    logic            rd_d_ff;
    logic            wr_d_ff;
    logic            hit;
    logic            hit_data;
    logic            hit_cmd;
    logic            rd_edge;
    logic            wr_edge;
    logic            tx_full_flag;
    logic            rx_empty_flag;
    logic            tx_ready;
    logic            tx_valid;
    byte_t           tx_data;
    logic            tx_pop;
    logic            rx_in_valid;
    byte_t           rx_in_data;
    logic            rx_valid;
    byte_t           rx_head;
    logic            rx_pop;
    logic            ser_valid;
    byte_t           ser_byte;
    logic            cmd_ack;
    logic            cmd_two;
    byte_t           cmd_reply;
    logic [8:0]      cmd_info;

    // Decode and access edges (strobes come from the same clock domain).
    assign hit      = (io_addr[`ADDR_W-1:`DEC_W] == '0)
                   && (io_addr[`DEC_W-1:1] == midi_port_base[`DEC_W-1:1]); // RULE1
    assign hit_data = hit && (io_addr[0] == `DATA_OFS); // RULE2
    assign hit_cmd  = hit && (io_addr[0] == `CMD_OFS);  // RULE2
    assign io_sel   = hit;
    assign rd_edge  = io_rd && !rd_d_ff;
    assign wr_edge  = io_wr && !wr_d_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_d_ff <= 1'b0;
            wr_d_ff <= 1'b0;
        end else begin
            rd_d_ff <= io_rd;
            wr_d_ff <= io_wr;
        end
    end

    // Command reply table.
    function automatic logic [8:0] reply_of(input byte_t c);
        if (c[7:3] == `CMD_A0_HI || c == `CMD_AB) begin
            reply_of = {1'b1, `REPLY_ZERO};
        end else if (c == `CMD_AC) begin
            reply_of = {1'b1, `REPLY_AC};
        end else if (c == `CMD_AD) begin
            reply_of = {1'b1, `REPLY_AD};
        end else if (c == `CMD_AF) begin
            reply_of = {1'b1, `REPLY_AF};
        end else begin
            reply_of = {1'b0, `REPLY_ZERO};
        end
    endfunction : reply_of

    assign cmd_ack   = hit_cmd && wr_edge && !pass_ff;   // RULE14 RULE16
    assign cmd_info  = reply_of(io_wdata);
    assign cmd_two   = cmd_info[8];                       // RULE15
    assign cmd_reply = cmd_info[7:0];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pass_ff <= 1'b0; // RULE12
        end else if (hit_cmd && wr_edge) begin
            if (!pass_ff && io_wdata == `CMD_ENTER) begin
                pass_ff <= 1'b1; // RULE14
            end else if (pass_ff && io_wdata == `CMD_EXIT) begin
                pass_ff <= 1'b0; // RULE20 RULE21
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            command_echo_bits_ff <= '0;
        end else if (hit_cmd && wr_edge) begin
            command_echo_bits_ff <= io_wdata[`ECHO_W-1:0]; // RULE5
        end
    end

    // Second reply byte follows the acknowledge one cycle later.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reply_pend_ff <= 1'b0;
            reply_ff      <= '0;
        end else if (cmd_ack && cmd_two) begin
            reply_pend_ff <= 1'b1; // RULE15
            reply_ff      <= cmd_reply;
        end else begin
            reply_pend_ff <= 1'b0;
        end
    end

    // Receive source mux; replies win, a serial byte that collides is held until no acknowledge or reply is pending.
    logic  ser_hold_ff;
    byte_t ser_hold_byte_ff;
    logic  ser_take;
    assign ser_take = ser_valid || ser_hold_ff;

    always_comb begin
        rx_in_valid = 1'b1;
        rx_in_data  = `ACK_BYTE;
        if (cmd_ack) begin
            rx_in_data = `ACK_BYTE; // RULE9
        end else if (reply_pend_ff) begin
            rx_in_data = reply_ff;
        end else if (ser_hold_ff) begin
            rx_in_data = ser_hold_byte_ff;
        end else if (ser_valid) begin
            rx_in_data = ser_byte; // RULE9
        end else begin
            rx_in_valid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ser_hold_ff      <= 1'b0;
            ser_hold_byte_ff <= '0;
        end else if ((cmd_ack || reply_pend_ff) && ser_valid) begin
            ser_hold_ff      <= 1'b1;
            ser_hold_byte_ff <= ser_byte;
        end else if (!cmd_ack && !reply_pend_ff) begin
            ser_hold_ff <= ser_take && ser_valid && ser_hold_ff;
            ser_hold_byte_ff <= ser_byte;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_rx_ff <= '0;
        end else if (rx_in_valid) begin
            last_rx_ff <= rx_in_data;
        end
    end

    assign rx_pop = hit_data && rd_edge && pass_ff; // RULE18

    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_rx_fifo ( // RULE4
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (rx_in_valid),
        .in_ready  (),
        .in_data   (rx_in_data),
        .in_ovr    (1'b1),      // RULE19
        .out_valid (rx_valid),
        .out_ready (rx_pop),
        .out_data  (rx_head)
    );

    assign rx_empty_flag = !rx_valid; // RULE7
    assign host_irq      = rx_valid;  // RULE8 RULE23

    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_tx_fifo ( // RULE4
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (hit_data && wr_edge && pass_ff), // RULE13 RULE17
        .in_ready  (tx_ready),
        .in_data   (io_wdata),
        .in_ovr    (1'b0),      // RULE22
        .out_valid (tx_valid),
        .out_ready (tx_pop),
        .out_data  (tx_data)
    );

    assign tx_full_flag = !tx_ready; // RULE6

    // Read data register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= '0;
        end else if (hit_cmd && io_rd) begin
            rdata_ff <= {rx_empty_flag, tx_full_flag, command_echo_bits_ff}; // RULE5 RULE6 RULE7
        end else if (hit_data && rd_edge) begin
            rdata_ff <= pass_ff ? rx_head : last_rx_ff; // RULE13 RULE18
        end
    end
    assign io_rdata = rdata_ff;

    // Transmitter.
    tx_state_t               tx_st_ff;
    logic [`BIT_CNT_W-1:0]   tx_cnt_ff;
    logic [3:0]              tx_bit_ff;
    logic [9:0]              tx_sh_ff;
    assign tx_pop = (tx_st_ff == TX_IDLE) && tx_valid; // RULE17

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_st_ff  <= TX_IDLE;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_sh_ff  <= '1;
        end else begin
            unique case (tx_st_ff)
                TX_IDLE: begin
                    if (tx_valid) begin
                        tx_sh_ff  <= {1'b1, tx_data, 1'b0}; // RULE11
                        tx_cnt_ff <= '0;
                        tx_bit_ff <= '0;
                        tx_st_ff  <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_cnt_ff == `BIT_CNT_W'(`BIT_CYC - 1)) begin // RULE10
                        tx_cnt_ff <= '0;
                        tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
                        if (tx_bit_ff == `LAST_BIT) begin
                            tx_st_ff <= TX_IDLE;
                        end else begin
                            tx_bit_ff <= tx_bit_ff + 4'h1;
                        end
                    end else begin
                        tx_cnt_ff <= tx_cnt_ff + `BIT_CNT_W'(1);
                    end
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end
    assign serial_midi_out = tx_sh_ff[0];

    // Receiver with two-stage input synchroniser.
    logic                  sync1_ff;
    logic                  sync2_ff;
    rx_state_t             rx_st_ff;
    logic [`BIT_CNT_W-1:0] rx_cnt_ff;
    logic [3:0]            rx_bit_ff;
    byte_t                 rx_sh_ff;
    logic                  ser_valid_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= serial_midi_in;
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st_ff     <= RX_IDLE;
            rx_cnt_ff    <= '0;
            rx_bit_ff    <= '0;
            rx_sh_ff     <= '0;
            ser_valid_ff <= 1'b0;
        end else begin
            ser_valid_ff <= 1'b0;
            unique case (rx_st_ff)
                RX_IDLE: begin
                    rx_cnt_ff <= '0;
                    if (!sync2_ff) begin
                        rx_st_ff <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_ff == `BIT_CNT_W'(`HALF_CYC - 1)) begin
                        rx_cnt_ff <= '0;
                        rx_bit_ff <= '0;
                        rx_st_ff  <= sync2_ff ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff + `BIT_CNT_W'(1);
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_ff == `BIT_CNT_W'(`BIT_CYC - 1)) begin // RULE10
                        rx_cnt_ff <= '0;
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (rx_bit_ff == `STOP_BIT) begin
                            ser_valid_ff <= sync2_ff; // RULE11
                            rx_st_ff     <= RX_IDLE;
                        end else begin
                            rx_sh_ff <= {sync2_ff, rx_sh_ff[7:1]};
                        end
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff + `BIT_CNT_W'(1);
                    end
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end
    assign ser_valid = ser_valid_ff;
    assign ser_byte  = rx_sh_ff;

    ack_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_ack && cmd_two) |=> (reply_pend_ff && rx_in_valid)) // RULE15
        else $error("Reply byte did not follow acknowledge.");
    mode_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_ack && io_wdata == `CMD_ENTER) |=> pass_ff) // RULE14
        else $error("Pass-through not entered.");
    mode_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pass_ff && hit_cmd && wr_edge && io_wdata == `CMD_EXIT) |=> !pass_ff) // RULE20
        else $error("Command-only not restored.");
    no_ack_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pass_ff && hit_cmd && wr_edge && !reply_pend_ff && !ser_take) |-> !rx_in_valid) // RULE21
        else $error("Acknowledge in pass-through mode.");
    irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        rx_in_valid |=> host_irq) // RULE8
        else $error("Interrupt missing after receive push.");
    status_echo_a: assert property (@(posedge clk) disable iff (sys_rst)
        (hit_cmd && wr_edge) |=> (command_echo_bits_ff == `ECHO_W'($past(io_wdata)))) // RULE5
        else $error("Status echo wrong.");
    drop_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!pass_ff && hit_data && wr_edge && !tx_valid) |=> !tx_valid) // RULE13
        else $error("Command-only data write queued.");
    tx_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        tx_pop |=> (tx_st_ff == TX_SHIFT) ##1 !serial_midi_out) // RULE17
        else $error("Transmitter did not start.");
endmodule : midi_uart_host_port
`default_nettype wire

// ===== src/midi_uart_pkg.sv
package midi_uart_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01
    } tx_state_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10
    } rx_state_t;
    typedef logic [7:0] byte_t;
endpackage : midi_uart_pkg
